/* pblc_cfg.svh */
`ifndef PBLC_CFG_SVH
`define PBLC_CFG_SVH

// Register byte offsets on the internal register port
`define PBLC_ADDR_LDO 8'h1d
`define PBLC_ADDR_PB 8'h30
`define PBLC_ADDR_CC0 8'h35
`define PBLC_ADDR_CC1 8'h36

// Reset values
`define PBLC_DEF_LDO 8'h32
`define PBLC_DEF_PB 8'h2e
`define PBLC_DEF_CC0 8'h20
`define PBLC_DEF_CC1 8'h00

// Regulator control fields
`define PBLC_LDO_EN_BIT 7
`define PBLC_LDO_CODE_HI 6
`define PBLC_LDO_CODE_LO 2
`define PBLC_LDO_SW_BIT 1
`define PBLC_LDO_BASE_MV 600
`define PBLC_LDO_STEP_MV 100

// Push-button timing fields
`define PBLC_PB_GATE_BIT 7
`define PBLC_PB_WAKE1_BIT 6
`define PBLC_PB_WAKE2_BIT 5
`define PBLC_PB_WARN_HI 4
`define PBLC_PB_WARN_LO 3
`define PBLC_PB_HOLD_HI 2
`define PBLC_PB_HOLD_LO 1

// Chip control fields
`define PBLC_CC0_SHIP_BIT 7
`define PBLC_CC0_WAKE_HI 5
`define PBLC_CC0_WAKE_LO 4
`define PBLC_CC0_MASK_BIT 2
`define PBLC_CC0_HWCMD_BIT 1
`define PBLC_CC0_SWCMD_BIT 0
`define PBLC_CC0_CMD_MASK 8'h03

// Times in milliseconds
`define PBLC_WAKE1_SHORT_MS 125
`define PBLC_WAKE1_LONG_MS 500
`define PBLC_WAKE2_SHORT_MS 1000
`define PBLC_WAKE2_LONG_MS 2000
`define PBLC_HOLD_0_MS 4000
`define PBLC_HOLD_1_MS 8000
`define PBLC_HOLD_2_MS 10000
`define PBLC_HOLD_3_MS 14000
`define PBLC_WARN_STEP_MS 500
`define PBLC_RESTART_0_MS 600
`define PBLC_RESTART_1_MS 1200
`define PBLC_RESTART_2_MS 2400
`define PBLC_RESTART_3_MS 5000

// Clock and timebase
`define PBLC_CLK_HZ 20000000
`define PBLC_TICK_US 1000
`define PBLC_TICK_CYCLES (`PBLC_CLK_HZ / 1000000 * `PBLC_TICK_US)

`endif

/* pblc_host.sv */
`timescale 1ns/100ps

module pblc_host
(
  // Clock
  input wire logic ref_clk,
  // Register port towards the block
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_write,
  output logic reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rdata_valid
);
  // Idle port at time zero
  initial
  begin
    reg_addr <= 8'h00;
    reg_wdata <= 8'h00;
    reg_write <= 1'b0;
    reg_read <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One write strobe; released lines show the inverse so stale values never match
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge ref_clk);
    reg_write <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask

  // Read strobe; data taken in the cycle the valid flag stands
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    #1;
    ok = reg_rdata_valid;
    d = reg_rdata;
    @(posedge ref_clk);
    reg_addr <= ~a;
  endtask
endmodule

/* pblc_pkg.sv */
package pblc_pkg;

  // Power sequencing states, one-hot
  typedef enum logic [2:0] {
    PBLC_ACTIVE = 3'b001,
    PBLC_RESTART = 3'b010,
    PBLC_SHIP = 3'b100
  } pblc_state_e;

  typedef logic [13:0] pblc_ms_t;

endpackage

/* pblc_tick_gen.sv */
`timescale 1ns/100ps
`include "pblc_cfg.svh"

module pblc_tick_gen
#(
  parameter int TICK_CYCLES = `PBLC_TICK_CYCLES
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Millisecond strobe
  output logic tick
);

  logic [14:0] div_reg;

  // Free-running divider; one-cycle strobe per period
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      div_reg <= 15'h0000;
      tick <= 1'b0;
    end
    else if (div_reg == 15'(TICK_CYCLES - 1))
    begin
      div_reg <= 15'h0000;
      tick <= 1'b1;
    end
    else
    begin
      div_reg <= div_reg + 15'h0001;
      tick <= 1'b0;
    end
  end

endmodule

/* pblc_top.sv */
// Summary of operation
// - Regulator output is on when its enable bit is 1 and rails are enabled; bit resets to 0.
// - Target voltage is 600 mV plus code times 100 mV; code resets to 01100.
// - Switch select 0 means linear regulator, 1 means load switch; resets to 1.
// - Gating bit 1 issues button reset only while input supply is valid.
// - First wake hold is 125 ms or 500 ms by its select bit.
// - Second wake hold is 1 s or 2 s by its select bit.
// - Button reset hold is 4, 8, 10 or 14 s; field resets to 11.
// - Warning precedes reset hold by 0.5 to 2.0 s; field resets to 01.
// - Ship enable enters ship mode once supply invalid and button released.
// - After button reset, wait 0.6, 1.2, 2.4 or 5 s before power-up.
// - Global mask set suppresses every interrupt indication.
// - Rail cycle command drops rails except always-on and restores defaults.
// - Register default command restores defaults without touching rails.
`timescale 1ns/100ps
`include "pblc_cfg.svh"

module pblc_top
#(
  parameter int TICK_CYCLES = `PBLC_TICK_CYCLES
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Register port from the serial engine
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  output logic reg_rdata_valid,
  // Board inputs
  input wire logic push_button_input_b,
  input wire logic supply_valid,
  input wire logic int_request,
  // Regulator control
  output logic regulator_on,
  output logic regulator_switch_mode,
  output logic [11:0] regulator_target_mv,
  // Power state, button events and the masked interrupt line
  output logic rails_enabled,
  output logic ship_mode,
  output logic wake_first,
  output logic wake_second,
  output logic reset_warning,
  output logic button_reset,
  output logic interrupt_out
);

  logic [7:0] ldo_reg;
  logic [7:0] pb_reg;
  logic [7:0] cc0_reg;
  logic [7:0] cc1_reg;
  pblc_pkg::pblc_ms_t press_ms_reg;
  pblc_pkg::pblc_ms_t restart_ms_reg;
  pblc_pkg::pblc_state_e state_reg;
  pblc_pkg::pblc_state_e state_next;
  logic tick;
  logic pressed;
  logic step;
  logic restore;
  logic wr_cc0;
  logic hw_cmd;
  logic sw_cmd;
  logic btn_go;
  logic hit_w1;
  logic hit_w2;
  logic hit_warn;
  logic hit_hold;
  logic ship_cond;
  pblc_pkg::pblc_ms_t press_inc;
  pblc_pkg::pblc_ms_t thr_w1;
  pblc_pkg::pblc_ms_t thr_w2;
  pblc_pkg::pblc_ms_t thr_hold;
  pblc_pkg::pblc_ms_t thr_warn;
  pblc_pkg::pblc_ms_t restart_load;

  pblc_tick_gen #(.TICK_CYCLES(TICK_CYCLES)) u_tick
  (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .tick(tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Threshold selection

  // Hold thresholds in milliseconds from the timing register
  always_comb
  begin
    thr_w1 = pb_reg[`PBLC_PB_WAKE1_BIT] ? 14'(`PBLC_WAKE1_LONG_MS) : 14'(`PBLC_WAKE1_SHORT_MS);
    thr_w2 = pb_reg[`PBLC_PB_WAKE2_BIT] ? 14'(`PBLC_WAKE2_LONG_MS) : 14'(`PBLC_WAKE2_SHORT_MS);
    case (pb_reg[`PBLC_PB_HOLD_HI:`PBLC_PB_HOLD_LO])
      2'h0: thr_hold = 14'(`PBLC_HOLD_0_MS);
      2'h1: thr_hold = 14'(`PBLC_HOLD_1_MS);
      2'h2: thr_hold = 14'(`PBLC_HOLD_2_MS);
      default: thr_hold = 14'(`PBLC_HOLD_3_MS);
    endcase
    // Lead is one step per code value plus one; shortest hold still exceeds it
    thr_warn = thr_hold - 14'(`PBLC_WARN_STEP_MS)
      * ({12'h000, pb_reg[`PBLC_PB_WARN_HI:`PBLC_PB_WARN_LO]} + 14'h0001);
    case (cc0_reg[`PBLC_CC0_WAKE_HI:`PBLC_CC0_WAKE_LO])
      2'h0: restart_load = 14'(`PBLC_RESTART_0_MS);
      2'h1: restart_load = 14'(`PBLC_RESTART_1_MS);
      2'h2: restart_load = 14'(`PBLC_RESTART_2_MS);
      default: restart_load = 14'(`PBLC_RESTART_3_MS);
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Press timing

  // A hit fires on the tick that brings the count onto the threshold
  assign pressed = !push_button_input_b;
  assign press_inc = press_ms_reg + 14'h0001;
  assign step = tick && pressed && (press_ms_reg != 14'h3fff);
  assign hit_w1 = step && (press_inc == thr_w1);
  assign hit_w2 = step && (press_inc == thr_w2);
  assign hit_warn = step && (press_inc == thr_warn) && (state_reg == pblc_pkg::PBLC_ACTIVE);
  assign hit_hold = step && (press_inc == thr_hold) && (state_reg == pblc_pkg::PBLC_ACTIVE);
  // Gate checked only at the threshold instant; a late supply gives no reset
  assign btn_go = hit_hold && (!pb_reg[`PBLC_PB_GATE_BIT] || supply_valid);

  // Press counter; a release clears it so no pending action survives
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
      press_ms_reg <= 14'h0000;
    else if (!pressed)
      press_ms_reg <= 14'h0000;
    else if (step)
      press_ms_reg <= press_inc;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register bank

  assign wr_cc0 = reg_write && (reg_addr == `PBLC_ADDR_CC0);
  assign hw_cmd = wr_cc0 && reg_wdata[`PBLC_CC0_HWCMD_BIT];
  assign sw_cmd = wr_cc0 && reg_wdata[`PBLC_CC0_SWCMD_BIT];
  assign restore = hw_cmd || sw_cmd || btn_go;

  // Restore wins over the write that triggered it; command bits never stored
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b || restore)
    begin
      ldo_reg <= `PBLC_DEF_LDO;
      pb_reg <= `PBLC_DEF_PB;
      cc0_reg <= `PBLC_DEF_CC0;
      cc1_reg <= `PBLC_DEF_CC1;
    end
    else if (reg_write)
    begin
      case (reg_addr)
        `PBLC_ADDR_LDO: ldo_reg <= reg_wdata;
        `PBLC_ADDR_PB: pb_reg <= reg_wdata;
        `PBLC_ADDR_CC0: cc0_reg <= reg_wdata & ~`PBLC_CC0_CMD_MASK;
        `PBLC_ADDR_CC1: cc1_reg <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Read data one cycle after the strobe; unmapped offsets read zero
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      reg_rdata <= 8'h00;
      reg_rdata_valid <= 1'b0;
    end
    else
    begin
      reg_rdata_valid <= reg_read;
      case (reg_addr)
        `PBLC_ADDR_LDO: reg_rdata <= ldo_reg;
        `PBLC_ADDR_PB: reg_rdata <= pb_reg;
        `PBLC_ADDR_CC0: reg_rdata <= cc0_reg;
        `PBLC_ADDR_CC1: reg_rdata <= cc1_reg;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power sequencing

  assign ship_cond = cc0_reg[`PBLC_CC0_SHIP_BIT] && !supply_valid && push_button_input_b;

  // Next state
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      pblc_pkg::PBLC_ACTIVE:
        if (btn_go || hw_cmd)
          state_next = pblc_pkg::PBLC_RESTART;
        else if (ship_cond)
          state_next = pblc_pkg::PBLC_SHIP;
      pblc_pkg::PBLC_RESTART:
        if (tick && (restart_ms_reg <= 14'h0001))
          state_next = pblc_pkg::PBLC_ACTIVE;
      pblc_pkg::PBLC_SHIP:
        if (supply_valid || hit_w1)
          state_next = pblc_pkg::PBLC_ACTIVE;
      default: state_next = pblc_pkg::PBLC_ACTIVE;
    endcase
  end

  // State and restart countdown; delay is latched on the edge defaults return, from the old setting
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      state_reg <= pblc_pkg::PBLC_ACTIVE;
      restart_ms_reg <= 14'h0000;
    end
    else
    begin
      state_reg <= state_next;
      if (state_reg == pblc_pkg::PBLC_ACTIVE && state_next == pblc_pkg::PBLC_RESTART)
        restart_ms_reg <= restart_load;
      else if (tick && restart_ms_reg != 14'h0000)
        restart_ms_reg <= restart_ms_reg - 14'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs

  // Rail, ship and regulator enable outputs follow the next state so rails and regulator drop together
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      rails_enabled <= 1'b1;
      ship_mode <= 1'b0;
      regulator_on <= 1'b0;
      regulator_switch_mode <= 1'b1;
      regulator_target_mv <= 12'h708;
    end
    else
    begin
      rails_enabled <= (state_next == pblc_pkg::PBLC_ACTIVE);
      ship_mode <= (state_next == pblc_pkg::PBLC_SHIP);
      regulator_on <= ldo_reg[`PBLC_LDO_EN_BIT] && (state_next == pblc_pkg::PBLC_ACTIVE);
      regulator_switch_mode <= ldo_reg[`PBLC_LDO_SW_BIT];
      regulator_target_mv <= 12'(`PBLC_LDO_BASE_MV) + 12'(`PBLC_LDO_STEP_MV)
        * {7'h00, ldo_reg[`PBLC_LDO_CODE_HI:`PBLC_LDO_CODE_LO]};
    end
  end

  // Event pulses and the masked interrupt line
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      wake_first <= 1'b0;
      wake_second <= 1'b0;
      reset_warning <= 1'b0;
      button_reset <= 1'b0;
      interrupt_out <= 1'b0;
    end
    else
    begin
      wake_first <= hit_w1;
      wake_second <= hit_w2;
      reset_warning <= hit_warn;
      button_reset <= btn_go;
      interrupt_out <= int_request && !cc0_reg[`PBLC_CC0_MASK_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  reg_enable_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    regulator_on |-> rails_enabled && $past(ldo_reg[7]))
    else $error("regulator on without enable");
  target_code_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    ##1 regulator_target_mv == 12'd600 + 12'd100 * {7'h00, $past(ldo_reg[6:2])})
    else $error("regulator target mismatch");
  switch_mode_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    ##1 regulator_switch_mode == $past(ldo_reg[1]))
    else $error("switch mode mismatch");
  supply_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    button_reset |-> $past(!pb_reg[7] || supply_valid) && pb_reg == 8'h2e)
    else $error("button reset while gated");
  ship_entry_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $rose(ship_mode) |-> $past(cc0_reg[7] && !supply_valid && push_button_input_b))
    else $error("ship mode without conditions");
  int_mask_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $past(cc0_reg[2]) |-> !interrupt_out)
    else $error("interrupt passed while masked");
  rail_cycle_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    hw_cmd && state_reg == pblc_pkg::PBLC_ACTIVE |=> !rails_enabled && ldo_reg == 8'h32)
    else $error("rail cycle command not obeyed");
  soft_default_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    sw_cmd && !hw_cmd && rails_enabled && state_next == pblc_pkg::PBLC_ACTIVE
    |=> rails_enabled && cc0_reg == 8'h20 && pb_reg == 8'h2e)
    else $error("default command misbehaved");
  release_cancel_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    push_button_input_b |=> press_ms_reg == 14'h0000 && !button_reset)
    else $error("release did not cancel timing");
  cmd_readback_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    reg_read && reg_addr == 8'h35 |=> reg_rdata_valid && reg_rdata[1:0] == 2'h0)
    else $error("command bits read nonzero");

endmodule

/* tb_pblc_top.sv */
`timescale 1ns/100ps
`include "pblc_cfg.svh"

module tb_pblc_top;
  // Short tick keeps multi-second holds inside the run budget
  localparam int TK = 1;
  localparam int LIMIT = 60000;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic push_button_input_b = 1'b1;
  logic supply_valid = 1'b1;
  logic int_request = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic reg_write, reg_read, reg_rdata_valid;
  logic regulator_on, regulator_switch_mode, rails_enabled, ship_mode;
  logic wake_first, wake_second, reset_warning, button_reset, interrupt_out;
  logic [11:0] regulator_target_mv;
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;
  int pcnt = 0;
  int roff = 0;
  int rlen = 0;
  int t1, t2, tw, tr;
  logic [7:0] cfg_t [3] = '{8'h80, 8'h7a, 8'h0e};
  logic [7:0] cc0_t [3] = '{8'h00, 8'h10, 8'h30};
  int w1_t [3] = '{125, 500, 125};
  int w2_t [3] = '{1000, 2000, 1000};
  int wn_t [3] = '{3500, 6000, 13000};
  int hd_t [3] = '{4000, 8000, 14000};
  int rs_t [3] = '{600, 1200, 5000};
  logic [7:0] ad_t [5] = '{`PBLC_ADDR_LDO, `PBLC_ADDR_PB, `PBLC_ADDR_CC0, `PBLC_ADDR_CC1, 8'h50};
  logic [7:0] df_t [5] = '{`PBLC_DEF_LDO, `PBLC_DEF_PB, `PBLC_DEF_CC0, `PBLC_DEF_CC1, 8'h00};

  pblc_top #(.TICK_CYCLES(TK)) pblc_top_i (.ref_clk(ref_clk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .reg_rdata_valid(reg_rdata_valid),
    .push_button_input_b(push_button_input_b), .supply_valid(supply_valid),
    .int_request(int_request), .regulator_on(regulator_on),
    .regulator_switch_mode(regulator_switch_mode), .regulator_target_mv(regulator_target_mv),
    .rails_enabled(rails_enabled), .ship_mode(ship_mode), .wake_first(wake_first),
    .wake_second(wake_second), .reset_warning(reset_warning), .button_reset(button_reset),
    .interrupt_out(interrupt_out));

  pblc_host pblc_host_i (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .reg_rdata_valid(reg_rdata_valid));

  // 50 ns clock
  initial
  begin
    forever #25 ref_clk = ~ref_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pulse times counted from the press, rail-off length, and the hang limit
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    pcnt <= push_button_input_b ? 0 : pcnt + 1;
    roff <= rails_enabled ? 0 : roff + 1;
    if (rails_enabled && roff > 0) rlen <= roff;
    if (wake_first && t1 < 0) t1 <= pcnt;
    if (wake_second && t2 < 0) t2 <= pcnt;
    if (reset_warning && tw < 0) tw <= pcnt;
    if (button_reset && tr < 0) tr <= pcnt;
    if (cycles == LIMIT)
    begin
      num_errors++;
      give_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    if (num_errors == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string name, input logic [11:0] exp, input logic [11:0] seen);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask

  // Times allow two ticks of slack either way plus three cycles for the registered pulse
  task automatic chk_t(input string name, input int exp_ms, input int seen);
    int e;
    e = exp_ms < 0 ? -1 : exp_ms * TK;
    check_count++;
    if (seen - e > 2 * TK + 3 || e - seen > 2 * TK + 3)
    begin
      num_errors++;
      $display("unexpected %s: expected %0d, seen %0d", name, e, seen);
    end
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic ok;
    pblc_host_i.rd(a, d, ok);
    chk("read valid", 12'h001, {11'h000, ok});
    chk("read data", {4'h0, e}, {4'h0, d});
  endtask

  // Holds the button for len ticks, or until the reset pulse fires
  task automatic press(input logic [7:0] cfg, input logic [7:0] cc0, input int len);
    int n;
    // Cleared ahead of the writes so the hold loop sees them settled
    t1 <= -1;
    t2 <= -1;
    tw <= -1;
    tr <= -1;
    pblc_host_i.wr(`PBLC_ADDR_PB, cfg);
    pblc_host_i.wr(`PBLC_ADDR_CC0, cc0);
    push_button_input_b <= 1'b0;
    for (n = 0; n < len * TK && tr < 0; n++) @(posedge ref_clk);
    @(posedge ref_clk);
    push_button_input_b <= 1'b1;
  endtask

  task automatic wait_rails(input int rs);
    int n;
    for (n = 0; n < 12000 && rails_enabled !== 1'b1; n++) @(posedge ref_clk);
    repeat (2) @(posedge ref_clk);
    chk_t("rail off time", rs, rlen);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 5; i++) rdc(ad_t[i], df_t[i]);
    chk("regulator on", 12'h000, 12'(regulator_on));
    chk("switch mode", 12'h001, 12'(regulator_switch_mode));
    chk("target mv", 12'h708, regulator_target_mv);
    pblc_host_i.wr(`PBLC_ADDR_LDO, 8'hfc);
    // Outputs follow the register one edge after the write lands
    repeat (2) @(posedge ref_clk);
    chk("regulator on", 12'h001, 12'(regulator_on));
    chk("switch mode", 12'h000, 12'(regulator_switch_mode));
    chk("target mv", 12'he74, regulator_target_mv);
    int_request <= 1'b1;
    repeat (2) @(posedge ref_clk);
    chk("interrupt", 12'h001, 12'(interrupt_out));
    pblc_host_i.wr(`PBLC_ADDR_CC0, 8'h24);
    repeat (2) @(posedge ref_clk);
    chk("interrupt", 12'h000, 12'(interrupt_out));
    pblc_host_i.wr(`PBLC_ADDR_CC0, 8'h01);
    repeat (2) @(posedge ref_clk);
    chk("interrupt", 12'h001, 12'(interrupt_out));
    chk("rails", 12'h001, 12'(rails_enabled));
    rdc(`PBLC_ADDR_CC0, 8'h20);
    rdc(`PBLC_ADDR_LDO, 8'h32);
    int_request <= 1'b0;
    // Regulator enabled first so the rail cycle has something to drop
    pblc_host_i.wr(`PBLC_ADDR_LDO, 8'hb0);
    pblc_host_i.wr(`PBLC_ADDR_CC0, 8'h02);
    #1;
    chk("rails", 12'h000, 12'(rails_enabled));
    chk("regulator on", 12'h000, 12'(regulator_on));
    rdc(`PBLC_ADDR_PB, 8'h2e);
    rdc(`PBLC_ADDR_LDO, 8'h32);
    wait_rails(2400);
    rdc(`PBLC_ADDR_CC0, 8'h20);
    for (int i = 0; i < 3; i++)
    begin
      press(cfg_t[i], cc0_t[i], hd_t[i] + 100);
      chk_t("wake first", w1_t[i], t1);
      chk_t("wake second", w2_t[i], t2);
      chk_t("reset warning", wn_t[i], tw);
      chk_t("button reset", hd_t[i], tr);
      rdc(`PBLC_ADDR_PB, 8'h2e);
      wait_rails(rs_t[i]);
    end
    supply_valid <= 1'b0;
    press(8'h94, 8'h00, 10100);
    chk_t("gated reset", -1, tr);
    chk_t("reset warning", 8500, tw);
    chk("rails", 12'h001, 12'(rails_enabled));
    chk("ship", 12'h000, 12'(ship_mode));
    supply_valid <= 1'b1;
    press(8'h00, 8'h00, 60);
    // Second short press reaches the first wake only if the count outlived release
    repeat (2) @(posedge ref_clk);
    push_button_input_b <= 1'b0;
    repeat (100 * TK) @(posedge ref_clk);
    push_button_input_b <= 1'b1;
    repeat (300 * TK) @(posedge ref_clk);
    chk_t("cancelled wake", -1, t1);
    pblc_host_i.wr(`PBLC_ADDR_CC0, 8'h80);
    repeat (3) @(posedge ref_clk);
    chk("ship", 12'h000, 12'(ship_mode));
    supply_valid <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk("ship", 12'h001, 12'(ship_mode));
    chk("rails", 12'h000, 12'(rails_enabled));
    supply_valid <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk("ship", 12'h000, 12'(ship_mode));
    give_verdict();
  end
endmodule
